// ---- rtl/duhp_consts.svh ----
// constants for the dual uart host port block
`ifndef DUHP_CONSTS_SVH
`define DUHP_CONSTS_SVH
`define DUHP_ADDR_MR_A 4'h0
`define DUHP_ADDR_SR_A 4'h1
`define DUHP_ADDR_CMD_A 4'h2
`define DUHP_ADDR_DATA_A 4'h3
`define DUHP_ADDR_ISR 4'h5
`define DUHP_ADDR_MR_B 4'h8
`define DUHP_ADDR_SR_B 4'h9
`define DUHP_ADDR_CMD_B 4'hA
`define DUHP_ADDR_DATA_B 4'hB
`define DUHP_ADDR_OUTPUT_PORT_CONFIG 4'hD
`define DUHP_ADDR_OP_SET 4'hE
`define DUHP_ADDR_OP_CLR 4'hF
`define DUHP_ADDR_IMR 4'h5
`define DUHP_RST_BYTE 8'h00
`define DUHP_OP_RST 8'hFF
`define DUHP_ISR_TX_A 0
`define DUHP_ISR_RX_A 1
`define DUHP_ISR_TX_B 4
`define DUHP_ISR_RX_B 5
`define DUHP_ISR_CT 3
`define DUHP_SR_RXRDY 0
`define DUHP_SR_TXRDY 2
`define DUHP_SR_TXEMT 3
`define DUHP_BAUD_DIV 16'd13
`define DUHP_FIFO_DEPTH 16
`endif

// ---- rtl/duhp_fifo.sv ----
// small valid/ready fifo in front of the transmitters
`timescale 1ns/1ps
module duhp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  // honest full and empty from the occupancy count
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // storage writes
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  // pointers and count
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- rtl/duhp_pkg.sv ----
// types shared by the dual uart host port block
package duhp_pkg;
  typedef enum logic [1:0] {
    DUHP_IDLE = 2'b00,
    DUHP_READ = 2'b01,
    DUHP_WRITE = 2'b11
  } duhp_bus_e;
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [3:0] addr;
  } duhp_strobe_s;
  typedef struct packed {
    logic chan_b;
    logic [7:0] data;
  } duhp_tx_s;
endpackage

// ---- rtl/duhp_top.sv ----
// host bus port, reset effects and output pin functions of the dual uart
`timescale 1ns/1ps
`include "duhp_consts.svh"
// Summary of operation
// - strobe protocol chosen when bus style input is high
// - eight-bit three-state data bus, bit zero least significant
// - chip select high keeps bus undriven and strobes ignored
// - transfers only while chip select low, steered by strobes and address
// - write loads addressed register on rising edge of write strobe
// - read drives addressed register from falling edge of read strobe
// - four address lines decode to registers and ports
// - reset clears status, mask, interrupt status, output port and config
// - reset forces output pins high and halts counter/timer
// - reset idles both channels with transmit lines at mark
// - reset returns mode pointer to first mode register
// - interrupt request pulled low when any unmasked condition true
// - receivers take bits least significant first
// - transmitters shift bits out least significant first
// - transmit line at mark when disabled, idle or in local loopback
// - pins zero and one: output or request-to-send with auto negate
// - pin two: output, or chan A 1x bit clock for every nonzero setting
// - pin three: output, open-drain timer, or chan B 1x clocks
// - pins four to six mirror status bits 1, 5, 0 open-drain
// - pin seven mirrors status bit 4 open-drain
// - serial lines idle high, start and break are low
module duhp_top
  import duhp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic bus_style_strobe,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  output logic irq_request_n_out,
  output logic irq_request_n_oe,
  input wire logic serial_in_chan_a,
  input wire logic serial_in_chan_b,
  output logic serial_out_chan_a,
  output logic serial_out_chan_b,
  output logic [7:0] out_pin_out,
  output logic [7:0] out_pin_oe
);
  // ------------------------------------------------------------
  // host strobe sampling
  // ------------------------------------------------------------
  duhp_strobe_s bus_q;
  logic wr_rise;
  logic rd_fall;
  logic sel_ok;
  logic [7:0] wdata_q;
  logic [7:0] chan_a_status_q, chan_b_status_q;
  logic [7:0] interrupt_mask_q, interrupt_status;
  logic [7:0] output_port_value_q, output_port_config_q;
  logic [1:0] mode_ptr_q;
  logic [7:0] mode_a_q, mode_b_q;
  logic [1:0] tx_en_q, rx_en_q, loop_q;
  logic [15:0] ct_q;
  logic ct_run_q, ct_out_q;
  logic [7:0] rx_a_q, rx_b_q;
  logic [1:0] rx_rdy_q;

  // only strobe style is honoured; other style blocks all access
  assign sel_ok = bus_style_strobe && !bus_q.cs_n;
  // write completes on rising edge of the write strobe
  assign wr_rise = sel_ok && !bus_q.wr_n && write_strobe_n;
  // read starts at falling edge of the read strobe
  assign rd_fall = bus_style_strobe && !chip_select_n && bus_q.rd_n && !read_strobe_n;

  // register the strobes and latch write data while strobe low
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bus_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 4'h0};
      wdata_q <= `DUHP_RST_BYTE;
    end else begin
      bus_q <= '{cs_n: chip_select_n, rd_n: read_strobe_n,
                 wr_n: write_strobe_n, addr: reg_addr};
      if (!write_strobe_n) begin
        wdata_q <= host_data_in;
      end
    end
  end

  function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
    hit = (a == b);
  endfunction

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  // reset clears the control registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      interrupt_mask_q <= `DUHP_RST_BYTE;
      output_port_value_q <= `DUHP_RST_BYTE;
      output_port_config_q <= `DUHP_RST_BYTE;
      mode_a_q <= `DUHP_RST_BYTE;
      mode_b_q <= `DUHP_RST_BYTE;
      tx_en_q <= 2'b00;
      rx_en_q <= 2'b00;
      loop_q <= 2'b00;
      mode_ptr_q <= 2'b00;
    end else if (wr_rise) begin
      if (hit(bus_q.addr, `DUHP_ADDR_IMR)) interrupt_mask_q <= wdata_q;
      if (hit(bus_q.addr, `DUHP_ADDR_OUTPUT_PORT_CONFIG)) output_port_config_q <= wdata_q;
      if (hit(bus_q.addr, `DUHP_ADDR_OP_SET)) begin
        output_port_value_q <= output_port_value_q | wdata_q;
      end
      if (hit(bus_q.addr, `DUHP_ADDR_OP_CLR)) begin
        output_port_value_q <= output_port_value_q & ~wdata_q;
      end
      if (hit(bus_q.addr, `DUHP_ADDR_MR_A)) begin
        mode_a_q <= wdata_q;
        mode_ptr_q[0] <= 1'b1;
        loop_q[0] <= wdata_q[7] && mode_ptr_q[0];
      end
      if (hit(bus_q.addr, `DUHP_ADDR_MR_B)) begin
        mode_b_q <= wdata_q;
        mode_ptr_q[1] <= 1'b1;
        loop_q[1] <= wdata_q[7] && mode_ptr_q[1];
      end
      // command: bit0 rx on, bit1 rx off, bit2 tx on, bit3 tx off
      if (hit(bus_q.addr, `DUHP_ADDR_CMD_A)) begin
        rx_en_q[0] <= (rx_en_q[0] | wdata_q[0]) & ~wdata_q[1];
        tx_en_q[0] <= (tx_en_q[0] | wdata_q[2]) & ~wdata_q[3];
        if (wdata_q[7:4] == 4'h1) mode_ptr_q[0] <= 1'b0;
      end
      if (hit(bus_q.addr, `DUHP_ADDR_CMD_B)) begin
        rx_en_q[1] <= (rx_en_q[1] | wdata_q[0]) & ~wdata_q[1];
        tx_en_q[1] <= (tx_en_q[1] | wdata_q[2]) & ~wdata_q[3];
        if (wdata_q[7:4] == 4'h1) mode_ptr_q[1] <= 1'b0;
      end
    end
  end
  // mode pointer returns to first mode register on reset above

  // ------------------------------------------------------------
  // transmit path through the fifo
  // ------------------------------------------------------------
  duhp_tx_s tx_in, tx_out;
  logic tx_in_valid, tx_in_ready, tx_out_valid, tx_take;
  assign tx_in.chan_b = bus_q.addr[3];
  assign tx_in.data = wdata_q;
  // writes while the fifo is full are dropped, txrdy tells software
  assign tx_in_valid = wr_rise && (hit(bus_q.addr, `DUHP_ADDR_DATA_A) ||
                       hit(bus_q.addr, `DUHP_ADDR_DATA_B)) &&
                       tx_en_q[bus_q.addr[3]];
  duhp_fifo #(.WIDTH(9), .DEPTH(`DUHP_FIFO_DEPTH)) u_tx_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_data(tx_in),
    .in_valid(tx_in_valid),
    .in_ready(tx_in_ready),
    .out_data(tx_out),
    .out_valid(tx_out_valid),
    .out_ready(tx_take)
  );

  // shifters: start bit, eight data bits, stop bit
  logic [15:0] baud_q;
  logic tick;
  logic [9:0] sh_q [2];
  logic [3:0] nb_q [2];
  logic [1:0] tx_busy;
  assign tick = (baud_q == `DUHP_BAUD_DIV);
  assign tx_take = tx_out_valid && tick && !tx_busy[tx_out.chan_b];
  always_ff @(posedge clock) begin
    if (!rst_n) baud_q <= 16'h0000;
    else baud_q <= tick ? 16'h0000 : baud_q + 16'h0001;
  end
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tx
      assign tx_busy[g] = (nb_q[g] != 4'h0);
      // reset leaves idle shifter holding mark
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          sh_q[g] <= 10'h3FF;
          nb_q[g] <= 4'h0;
        end else if (tick) begin
          if (tx_take && tx_out.chan_b == 1'(g)) begin
            // start bit low, stop bit high
            sh_q[g] <= {1'b1, tx_out.data, 1'b0};
            nb_q[g] <= 4'hA;
          end else if (tx_busy[g]) begin
            // shift right so bit zero leaves first
            sh_q[g] <= {1'b1, sh_q[g][9:1]};
            nb_q[g] <= nb_q[g] - 4'h1;
          end
        end
      end
    end
  endgenerate

  // mark unless enabled, busy and not looped back
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      serial_out_chan_a <= 1'b1;
      serial_out_chan_b <= 1'b1;
    end else begin
      serial_out_chan_a <= (tx_en_q[0] && tx_busy[0] && !loop_q[0]) ? sh_q[0][0] : 1'b1;
      serial_out_chan_b <= (tx_en_q[1] && tx_busy[1] && !loop_q[1]) ? sh_q[1][0] : 1'b1;
    end
  end

  // ------------------------------------------------------------
  // receive: simple mid-bit sampler per channel
  // ------------------------------------------------------------
  logic [1:0] rx_line;
  logic [9:0] rsh_q [2];
  logic [3:0] rnb_q [2];
  logic [7:0] rph_q [2];
  assign rx_line[0] = loop_q[0] ? sh_q[0][0] : serial_in_chan_a;
  assign rx_line[1] = loop_q[1] ? sh_q[1][0] : serial_in_chan_b;
  generate
    for (g = 0; g < 2; g++) begin : g_rx
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          rsh_q[g] <= 10'h000;
          rnb_q[g] <= 4'h0;
          rph_q[g] <= 8'h00;
          rx_rdy_q[g] <= 1'b0;
        end else begin
          // live address: the registered copy still holds the previous access here
          if (rd_fall && reg_addr == (g ? `DUHP_ADDR_DATA_B : `DUHP_ADDR_DATA_A))
            rx_rdy_q[g] <= 1'b0;
          if (!rx_en_q[g]) begin
            rnb_q[g] <= 4'h0;
          end else if (rnb_q[g] == 4'h0) begin
            // low on an idle line is a start bit
            if (!rx_line[g]) begin
              rnb_q[g] <= 4'hA;
              // start half a bit in so every sample lands mid-bit
              rph_q[g] <= 8'(`DUHP_BAUD_DIV >> 1);
            end
          end else if (rph_q[g] == 8'(`DUHP_BAUD_DIV)) begin
            rph_q[g] <= 8'h00;
            // first bit lands lowest after the shifts
            rsh_q[g] <= {rx_line[g], rsh_q[g][9:1]};
            rnb_q[g] <= rnb_q[g] - 4'h1;
            if (rnb_q[g] == 4'h1) rx_rdy_q[g] <= 1'b1;
          end else begin
            rph_q[g] <= rph_q[g] + 8'h01;
          end
        end
      end
    end
  endgenerate
  assign rx_a_q = rsh_q[0][8:1];
  assign rx_b_q = rsh_q[1][8:1];

  // status bytes: ready, fifo room, empty
  // empty only reported for an enabled transmitter, so reset reads back clear
  assign chan_a_status_q = {4'h0, !tx_busy[0] && tx_en_q[0], tx_in_ready && tx_en_q[0], 1'b0,
                            rx_rdy_q[0]};
  assign chan_b_status_q = {4'h0, !tx_busy[1] && tx_en_q[1], tx_in_ready && tx_en_q[1], 1'b0,
                            rx_rdy_q[1]};

  // ------------------------------------------------------------
  // counter/timer
  // ------------------------------------------------------------
  // reset halts the timer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ct_q <= 16'h0000;
      ct_run_q <= 1'b0;
      ct_out_q <= 1'b1;
    end else begin
      ct_run_q <= output_port_config_q[3:2] == 2'b01;
      ct_q <= ct_run_q ? ct_q + 16'h0001 : 16'h0000;
      if (ct_run_q && ct_q == 16'hFFFF) ct_out_q <= !ct_out_q;
    end
  end

  // interrupt status is built live from the conditions
  assign interrupt_status = {2'b00, rx_rdy_q[1], chan_b_status_q[`DUHP_SR_TXRDY],
                             !ct_out_q, 1'b0, rx_rdy_q[0], chan_a_status_q[`DUHP_SR_TXRDY]};

  // ------------------------------------------------------------
  // read data and bus drive
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      host_data_out <= `DUHP_RST_BYTE;
      host_data_oe <= 1'b0;
    end else begin
      // chip select high forces the bus undriven
      host_data_oe <= bus_style_strobe && !chip_select_n && !read_strobe_n;
      if (rd_fall) begin
        case (reg_addr)
          `DUHP_ADDR_MR_A: host_data_out <= mode_a_q;
          `DUHP_ADDR_SR_A: host_data_out <= chan_a_status_q;
          `DUHP_ADDR_DATA_A: host_data_out <= rx_a_q;
          `DUHP_ADDR_ISR: host_data_out <= interrupt_status;
          `DUHP_ADDR_MR_B: host_data_out <= mode_b_q;
          `DUHP_ADDR_SR_B: host_data_out <= chan_b_status_q;
          `DUHP_ADDR_DATA_B: host_data_out <= rx_b_q;
          `DUHP_ADDR_OUTPUT_PORT_CONFIG: host_data_out <= output_port_config_q;
          default: host_data_out <= `DUHP_RST_BYTE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt and output pins
  // ------------------------------------------------------------
  logic [7:0] pin_val;
  logic [7:0] pin_od;
  always_comb begin
    pin_val = ~output_port_value_q;
    pin_od = 8'h00;
    if (mode_a_q[7] && rx_rdy_q[0]) pin_val[0] = 1'b1;
    if (mode_b_q[7] && rx_rdy_q[1]) pin_val[1] = 1'b1;
    // pin two carries chan A bit clock
    if (output_port_config_q[1:0] != 2'b00) pin_val[2] = tick;
    // pin three: timer open-drain or chan B clock
    if (output_port_config_q[3:2] == 2'b01) begin
      pin_val[3] = ct_out_q;
      pin_od[3] = 1'b1;
    end else if (output_port_config_q[3:2] != 2'b00) begin
      pin_val[3] = tick;
    end
    // pins four to six mirror status bits
    // pin seven mirrors chan B transmit
    if (output_port_config_q[4]) begin pin_val[4] = !interrupt_status[`DUHP_ISR_RX_A]; pin_od[4] = 1'b1; end
    if (output_port_config_q[5]) begin pin_val[5] = !interrupt_status[`DUHP_ISR_RX_B]; pin_od[5] = 1'b1; end
    if (output_port_config_q[6]) begin pin_val[6] = !interrupt_status[`DUHP_ISR_TX_A]; pin_od[6] = 1'b1; end
    if (output_port_config_q[7]) begin pin_val[7] = !interrupt_status[`DUHP_ISR_TX_B]; pin_od[7] = 1'b1; end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_pin_out <= `DUHP_OP_RST;
      out_pin_oe <= 8'hFF;
      irq_request_n_out <= 1'b0;
      irq_request_n_oe <= 1'b0;
    end else begin
      // open-drain pins drive only their low level
      out_pin_out <= pin_val & ~pin_od;
      out_pin_oe <= ~pin_od | ~pin_val;
      // any unmasked condition pulls request low
      irq_request_n_out <= 1'b0;
      irq_request_n_oe <= |(interrupt_status & interrupt_mask_q);
    end
  end
endmodule

// ---- sim/duhp_host_model.sv ----
// host processor model driving the strobe bus of the dual uart
`timescale 1ns/1ps
module duhp_host_model (
  input wire logic clock,
  input wire logic [7:0] dev_data,
  input wire logic dev_oe,
  output logic bus_style_strobe,
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [3:0] reg_addr,
  output logic [7:0] bus_level
);
  logic [7:0] wdata_q = 8'h00;
  logic drive_q = 1'b0;
  // released bus shows device data, or the inverse of the last byte when the device is not driving, so stale data never passes
  assign bus_level = drive_q ? wdata_q : (dev_oe ? dev_data : ~wdata_q);
  // idle bus from time zero
  initial begin
    bus_style_strobe = 1'b1;
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    reg_addr = 4'h0;
  end
  task automatic set_style(input logic v);
    @(posedge clock);
    bus_style_strobe <= v;
  endtask
  // one strobe cycle, held until the sampling edge has passed
  task automatic access(input logic w, input logic cs_n, input logic [3:0] a,
                        input logic [7:0] d, output logic [7:0] q, output logic oe);
    @(posedge clock);
    chip_select_n <= cs_n;
    reg_addr <= a;
    if (w) begin
      write_strobe_n <= 1'b0;
      wdata_q <= d;
      drive_q <= 1'b1;
    end else begin
      read_strobe_n <= 1'b0;
    end
    @(posedge clock);
    write_strobe_n <= 1'b1;
    @(posedge clock);
    q = dev_data;
    oe = dev_oe;
    read_strobe_n <= 1'b1;
    chip_select_n <= 1'b1;
    drive_q <= 1'b0;
  endtask
endmodule

// ---- sim/duhp_top_asserts.sv ----
// assertion checker on the ports of the dual uart host port top
`timescale 1ns/1ps
module duhp_top_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic bus_style_strobe,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] host_data_in,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe,
  input wire logic irq_request_n_out,
  input wire logic irq_request_n_oe,
  input wire logic serial_out_chan_a,
  input wire logic serial_out_chan_b,
  input wire logic [7:0] out_pin_out,
  input wire logic [7:0] out_pin_oe
);
  // ----------------------------------------
  // reset effects, checked while reset is low
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_rst_pins; disable iff (1'b0) !rst_n |=> out_pin_out == 8'hFF && out_pin_oe == 8'hFF; endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pins not high in reset");
  property p_rst_tx; disable iff (1'b0) !rst_n |=> serial_out_chan_a && serial_out_chan_b && !host_data_oe; endproperty
  a_rst_tx: assert property (p_rst_tx) else $error("line or bus active in reset");
  // ----------------------------------------
  // host bus and pins
  // ----------------------------------------
  // deselect floats bus
  property p_cs_hiz; chip_select_n |=> !host_data_oe; endproperty
  a_cs_hiz: assert property (p_cs_hiz) else $error("bus driven while deselected");
  property p_rd_drive; !chip_select_n && !read_strobe_n && bus_style_strobe |=> host_data_oe; endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read did not drive bus");
  property p_style_off; !bus_style_strobe |=> !host_data_oe; endproperty
  a_style_off: assert property (p_style_off) else $error("bus driven in other style");
  property p_rd_hold; $rose(host_data_oe) |=> $stable(host_data_out); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_irq_od; irq_request_n_oe |-> !irq_request_n_out; endproperty
  a_irq_od: assert property (p_irq_od) else $error("request drives high");
  property p_start_bit; $fell(serial_out_chan_a) |-> !serial_out_chan_a [*8]; endproperty
  a_start_bit: assert property (p_start_bit) else $error("short start bit");
  property p_op_set;
    $rose(write_strobe_n) && !chip_select_n && bus_style_strobe && reg_addr == 4'hE
      |=> ##1 (out_pin_out & $past(host_data_in, 2) & 8'h0E) == 8'h00;
  endproperty
  a_op_set: assert property (p_op_set) else $error("output bit not set");
  c_read: cover property ($rose(host_data_oe));
  c_irq: cover property ($rose(irq_request_n_oe));
  c_frame_b: cover property ($fell(serial_out_chan_b));
endmodule

bind duhp_top duhp_top_checker i_duhp_top_checker (
  .clock(clock), .rst_n(rst_n), .bus_style_strobe(bus_style_strobe),
  .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
  .write_strobe_n(write_strobe_n), .reg_addr(reg_addr), .host_data_in(host_data_in),
  .host_data_out(host_data_out), .host_data_oe(host_data_oe),
  .irq_request_n_out(irq_request_n_out), .irq_request_n_oe(irq_request_n_oe),
  .serial_out_chan_a(serial_out_chan_a), .serial_out_chan_b(serial_out_chan_b),
  .out_pin_out(out_pin_out), .out_pin_oe(out_pin_oe)
);

// ---- sim/test_dual_uart_host_bus_and_pins.sv ----
// self-checking bench for the dual uart host port top
`timescale 1ns/1ps
`include "duhp_consts.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module test_dual_uart_host_bus_and_pins;
  logic clock, rst_n, cs_n, rd_n, wr_n, style, oe, irq_out, irq_oe, tx_a, tx_b, rx_a, rx_b, qoe;
  logic [3:0] addr;
  logic [7:0] bus, dout, pins, pins_oe, q, v;
  logic [7:0] opr_m = 8'h00;
  logic [7:0] exp_q[$];
  logic [7:0] got_q[2][$];
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  integer seed = 63;
  duhp_top i_duhp_top (
    .clock(clock), .rst_n(rst_n), .bus_style_strobe(style), .chip_select_n(cs_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .reg_addr(addr), .host_data_in(bus),
    .host_data_out(dout), .host_data_oe(oe), .irq_request_n_out(irq_out),
    .irq_request_n_oe(irq_oe), .serial_in_chan_a(rx_a), .serial_in_chan_b(rx_b),
    .serial_out_chan_a(tx_a), .serial_out_chan_b(tx_b), .out_pin_out(pins),
    .out_pin_oe(pins_oe)
  );
  duhp_host_model i_duhp_host_model (
    .clock(clock), .dev_data(dout), .dev_oe(oe), .bus_style_strobe(style),
    .chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .reg_addr(addr),
    .bus_level(bus)
  );
  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // hang guard, far above the thousand or so cycles the run needs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // selected access, then two edges so registered outputs have landed
  task automatic bus_op(input logic w, input logic [3:0] a, input logic [7:0] d);
    i_duhp_host_model.access(w, 1'b0, a, d, q, qoe);
    repeat (2) @(negedge clock);
    if (!w) begin
      `CHK(qoe, 1'b1)
    end
  endtask
  // remote frame: low start, lsb first, high stop, 14 clocks a bit
  task automatic send_frame(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      rx_a <= f[i];
      repeat (13) @(posedge clock);
    end
  endtask
  // line monitor: start edge, then the middle of each bit
  task automatic watch(input int ch);
    logic [7:0] b;
    forever begin
      @(posedge clock);
      if ((ch ? tx_b : tx_a) === 1'b0 && rst_n === 1'b1) begin
        repeat (7) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
          repeat (14) @(posedge clock);
          b[i] = ch ? tx_b : tx_a;
        end
        repeat (14) @(posedge clock);
        `CHK(ch ? tx_b : tx_a, 1'b1)
        got_q[ch].push_back(b);
      end
    end
  endtask
  initial begin
    fork
      watch(0);
      watch(1);
    join
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    rx_a = 1'b1;
    rx_b = 1'b1;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    `CHK({pins, pins_oe, tx_a, tx_b}, 18'h3_FFFF)
    bus_op(1'b0, `DUHP_ADDR_SR_A, 8'h00);
    `CHK(q, `DUHP_RST_BYTE)
    bus_op(1'b0, `DUHP_ADDR_ISR, 8'h00);
    `CHK(q, `DUHP_RST_BYTE)
    // random set and clear of the output port
    for (int k = 0; k < 4; k++) begin
      v = $random(seed);
      bus_op(1'b1, `DUHP_ADDR_OP_SET, v);
      opr_m = opr_m | v;
      `CHK(pins, ~opr_m)
      v = $random(seed);
      bus_op(1'b1, `DUHP_ADDR_OP_CLR, v);
      opr_m = opr_m & ~v;
      `CHK(pins, ~opr_m)
    end
    // deselected and wrong-style accesses are ignored
    i_duhp_host_model.access(1'b1, 1'b1, `DUHP_ADDR_OP_SET, 8'hFF, q, qoe);
    i_duhp_host_model.access(1'b0, 1'b1, `DUHP_ADDR_SR_A, 8'h00, q, qoe);
    `CHK({qoe, pins}, {1'b0, ~opr_m})
    i_duhp_host_model.set_style(1'b0);
    i_duhp_host_model.access(1'b1, 1'b0, `DUHP_ADDR_OP_SET, 8'hFF, q, qoe);
    i_duhp_host_model.set_style(1'b1);
    repeat (2) @(negedge clock);
    `CHK(pins, ~opr_m)
    // enable channels, mask and unmask the request
    bus_op(1'b1, `DUHP_ADDR_CMD_A, 8'h05);
    bus_op(1'b1, `DUHP_ADDR_CMD_B, 8'h04);
    bus_op(1'b0, `DUHP_ADDR_ISR, 8'h00);
    `CHK({q & 8'h33, irq_oe}, {8'h11, 1'b0})
    bus_op(1'b1, `DUHP_ADDR_IMR, 8'h10);
    `CHK({irq_oe, irq_out}, 2'b10)
    bus_op(1'b1, `DUHP_ADDR_IMR, 8'h02);
    `CHK(irq_oe, 1'b0)
    // two back-to-back characters on each channel
    for (int ch = 0; ch < 2; ch++) begin
      for (int k = 0; k < 2; k++) begin
        v = $random(seed);
        exp_q.push_back(v);
        bus_op(1'b1, ch ? `DUHP_ADDR_DATA_B : `DUHP_ADDR_DATA_A, v);
      end
      for (int n = 0; n < 800 && got_q[ch].size() < 2; n++) @(posedge clock);
      `CHK(got_q[ch].size(), 2)
      for (int k = 0; k < 2; k++) begin
        q = (got_q[ch].size() > 0) ? got_q[ch].pop_front() : 8'hxx;
        v = exp_q.pop_front();
        `CHK(q, v)
      end
    end
    // receive on A, then interrupt pins follow the status
    v = $random(seed);
    send_frame(v);
    bus_op(1'b1, `DUHP_ADDR_OUTPUT_PORT_CONFIG, 8'h50);
    `CHK({pins_oe[6:4], pins[6:4], irq_oe}, {3'b111, 1'b0, ~opr_m[5], 1'b0, 1'b1})
    bus_op(1'b0, `DUHP_ADDR_DATA_A, 8'h00);
    `CHK(q, v)
    `CHK({pins_oe[4], irq_oe}, 2'b00)
    // loopback set through the second mode register write keeps the line at mark
    bus_op(1'b1, `DUHP_ADDR_MR_A, 8'h00);
    bus_op(1'b1, `DUHP_ADDR_MR_A, 8'h80);
    bus_op(1'b1, `DUHP_ADDR_DATA_A, 8'h00);
    repeat (200) @(posedge clock);
    `CHK(got_q[0].size(), 0)
    // reset in mid-run
    bus_op(1'b1, `DUHP_ADDR_OP_SET, 8'h0F);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    `CHK({pins, pins_oe}, 16'hFFFF)
    bus_op(1'b0, `DUHP_ADDR_ISR, 8'h00);
    `CHK(q, `DUHP_RST_BYTE)
    print_verdict();
  end
endmodule
